// ### rtl/ble_pkg.sv
// shared constants, codes and decode functions for the branch and load executor
package ble_pkg;
	localparam int APB_AW = 8;
	localparam logic [7:0] REG_INSTR = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_PC = 8'h08;
	localparam logic [7:0] REG_AB = 8'h0C;
	localparam logic [7:0] REG_F = 8'h10;
	localparam logic [7:0] REG_SP = 8'h14;
	localparam logic [7:0] REG_X = 8'h18;
	localparam logic [7:0] REG_Y = 8'h1C;
	localparam logic [7:0] REG_EXT = 8'h20;
	localparam int FLAG_E = 3;
	localparam int FLAG_I = 2;
	localparam int FLAG_C = 1;
	localparam int FLAG_Z = 0;
	localparam logic [12:0] CODE_INC_RSP = 13'h1FE8;
	localparam logic [12:0] CODE_INC_DSP = 13'h1FEC;
	localparam logic [6:0] PFX_TRAP = 7'h7E;
	localparam logic [11:0] PFX_JMP_Y = 12'hFF9;
	localparam logic [12:0] CODE_REL_A = 13'h1FF1;
	localparam logic [12:0] CODE_REL_BA = 13'h1FF0;
	localparam logic [6:0] PFX_REL_MEM = 7'h7D;
	localparam logic [12:0] CODE_LD_AA = 13'h1EF0;
	localparam logic [12:0] CODE_LD_AB = 13'h1EF2;
	localparam logic [12:0] CODE_LD_AF = 13'h1FF6;
	localparam logic [12:0] CODE_LD_BA = 13'h1EF4;
	localparam logic [12:0] CODE_LD_BB = 13'h1EF6;
	localparam logic [12:0] CODE_LD_FA = 13'h1FF5;
	localparam logic [8:0] PFX_LDI_A = 9'h1EC;
	localparam logic [8:0] PFX_LDI_B = 9'h1ED;
	localparam logic [8:0] PFX_LDI_F = 9'h10B;
	localparam logic [9:0] PFX_LDIND = 10'h3DC;
	localparam logic [2:0] COND_NONE = 3'h0;
	localparam logic [2:0] COND_C = 3'h4;
	localparam logic [2:0] COND_NC = 3'h5;
	localparam logic [2:0] COND_Z = 3'h6;
	localparam logic [2:0] COND_NZ = 3'h7;
	localparam logic [15:0] VEC_BASE = 16'h0100;
	localparam logic [7:0] PAGE_LO = 8'h00;
	localparam logic [7:0] PAGE_HI = 8'hFF;
	localparam logic [1:0] CYC_TRAP = 2'h3;
	localparam logic [1:0] CYC_REL_MEM = 2'h2;
	localparam logic [1:0] CYC_ONE = 2'h1;
	localparam logic [2:0] CLK_PER_CYC = 3'h2;

	typedef enum logic [3:0] {OP_NONE, OP_INCSP, OP_TRAP, OP_JMP_Y, OP_REL_A, OP_REL_BA,
		OP_REL_MEM, OP_REL_S8, OP_LDRR, OP_LDIMM, OP_LDIND} ble_op_t;
	typedef enum logic {ST_IDLE, ST_EXEC} ble_st_t;

	function automatic ble_op_t ble_decode(input logic [12:0] c);
		ble_op_t o;
		o = OP_NONE;
		if ((c == CODE_INC_RSP) || (c == CODE_INC_DSP))
			o = OP_INCSP;
		else if (c[12:6] == PFX_TRAP)
			o = OP_TRAP;
		else if (c[12:1] == PFX_JMP_Y)
			o = OP_JMP_Y;
		else if (c == CODE_REL_A)
			o = OP_REL_A;
		else if (c == CODE_REL_BA)
			o = OP_REL_BA;
		else if (c[12:6] == PFX_REL_MEM)
			o = OP_REL_MEM;
		else if ((c[12:11] == 2'h0) && (c[10] || (c[10:8] == COND_NONE)))
			o = OP_REL_S8;
		else if ((c == CODE_LD_AA) || (c == CODE_LD_AB) || (c == CODE_LD_AF)
			|| (c == CODE_LD_BA) || (c == CODE_LD_BB) || (c == CODE_LD_FA))
			o = OP_LDRR;
		else if ((c[12:4] == PFX_LDI_A) || (c[12:4] == PFX_LDI_B) || (c[12:4] == PFX_LDI_F))
			o = OP_LDIMM;
		else if ((c[12:3] == PFX_LDIND) && !c[0])
			o = OP_LDIND;
		return o;
	endfunction

	function automatic logic [1:0] ble_ncyc(input ble_op_t o);
		if (o == OP_TRAP)
			return CYC_TRAP;
		else if (o == OP_REL_MEM)
			return CYC_REL_MEM;
		return CYC_ONE;
	endfunction
endpackage

// ### rtl/ble_cycle.sv
// instruction cycle timer: two clocks per cycle, one to three cycles
module ble_cycle (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic start,
	input wire logic [1:0] ncyc,
	output logic [2:0] cnt,
	output logic last
);
	import ble_pkg::*;

	typedef struct packed {
		logic run;
		logic [2:0] cnt;
		logic [2:0] lim;
	} ble_cyc_t;

	ble_cyc_t q;
	ble_cyc_t d;

	always_comb
	begin
		d = q;
		if (start)
		begin
			d.run = 1'b1;
			d.cnt = 3'h0;
			d.lim = 3'({1'b0, ncyc} * CLK_PER_CYC - 3'h1);
		end
		else if (q.run)
		begin
			if (q.cnt == q.lim)
				d.run = 1'b0;
			else
				d.cnt = q.cnt + 3'h1;
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			q <= '0;
		else if (ce)
			q <= d;
	end

	assign cnt = q.cnt;
	assign last = q.run & (q.cnt == q.lim);
endmodule // ble_cycle

// ### rtl/ble_target.sv
// next program counter: fall-through, relative, indirect and vector targets
module ble_target (
	input wire ble_pkg::ble_op_t op,
	input wire logic [15:0] pc,
	input wire logic [15:0] y,
	input wire logic [3:0] a,
	input wire logic [3:0] b,
	input wire logic [3:0] mem,
	input wire logic [7:0] imm,
	input wire logic [7:0] ext,
	input wire logic ext_on,
	input wire logic take,
	output logic [15:0] target
);
	import ble_pkg::*;

	logic [15:0] nxt;
	logic [15:0] off;

	always_comb
	begin
		nxt = pc + 16'h0001;
		off = 16'h0000;
		case (op)
			OP_JMP_Y: target = y;
			OP_TRAP: target = VEC_BASE + {10'h000, imm[5:0]};
			OP_REL_A: target = nxt + {12'h000, a};
			OP_REL_BA: target = nxt + {8'h00, b, a};
			OP_REL_MEM: target = nxt + {12'h000, mem};
			OP_REL_S8:
			begin
				off = {{8{imm[7]}}, imm};
				if (ext_on)
					off = {ext, imm};
				target = take ? nxt + off : nxt;
			end
			default: target = nxt;
		endcase
	end
endmodule // ble_target

// ### rtl/ble_exec.sv
// branch, trap and register-load executor with an apb register port
// What this block does
// - stack pointer increment keeps carry, sets zero
// - trap saves flags, return address, then vectors
// - indirect jump loads pc from second pointer
// - jump forward by low digit register
// - jump forward by digit pair, one cycle
// - two-cycle jump by data memory nibble
// - extension byte widens displacement to sixteen bits
// - branch taken only when carry set
// - branch taken only when carry clear
// - branch taken only when zero clear
// - branch taken only when zero set
// - register copies among digits and flags
// - immediate constant loads into digits or flags
// - single-cycle indirect load through either pointer
// - extension byte pages indirect load address
////////////////////////////////////////////////////////////////////////////////
module ble_exec (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ble_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [15:0] dm_addr,
	output logic dm_rd,
	output logic dm_wr,
	output logic [3:0] dm_wdata,
	input wire logic [3:0] dm_rdata
);
	import ble_pkg::*;

	typedef struct packed {
		ble_st_t st;
		logic [12:0] ir;
		logic [15:0] pc;
		logic [3:0] a;
		logic [3:0] b;
		logic [3:0] f;
		logic [7:0] rsp;
		logic [7:0] dsp;
		logic [15:0] x;
		logic [15:0] y;
		logic [7:0] ext;
		logic [3:0] mem;
		logic [15:0] dm_addr;
		logic dm_rd;
		logic dm_wr;
		logic [3:0] dm_wdata;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} ble_state_t;

	ble_state_t q;
	ble_state_t d;
	ble_op_t op;
	ble_op_t acc_op;
	logic busy;
	logic wr_ok;
	logic acc;
	logic take;
	logic fire;
	logic tm_last;
	logic [2:0] tm_cnt;
	logic [15:0] tgt;
	logic [15:0] ret_addr;
	logic [15:0] rsp_base;
	logic [7:0] sp_sum;

	function automatic logic [15:0] ind_addr(input logic [12:0] c, input logic [15:0] x,
		input logic [15:0] y, input logic [7:0] ext, input logic ext_on);
		if (ext_on)
			return {(c[1] ? PAGE_HI : PAGE_LO), ext};
		return c[1] ? y : x;
	endfunction

	assign op = ble_decode(q.ir);
	assign acc_op = ble_decode(pwdata[12:0]);
	assign busy = (q.st == ST_EXEC);
	assign wr_ok = psel & penable & q.pready & pwrite & ~q.pslverr;
	assign acc = wr_ok & (paddr == REG_INSTR);
	assign fire = tm_last & ce;
	assign ret_addr = q.pc + 16'h0001;
	assign rsp_base = {6'h00, q.rsp - 8'h01, 2'h0};
	assign sp_sum = (q.ir[2] ? q.dsp : q.rsp) + 8'h01;

	////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		case (q.ir[10:8])
			COND_C: take = q.f[FLAG_C];
			COND_NC: take = ~q.f[FLAG_C];
			COND_Z: take = q.f[FLAG_Z];
			COND_NZ: take = ~q.f[FLAG_Z];
			default: take = 1'b1;
		endcase
	end

	ble_cycle u_cycle (
		.core_clk(core_clk),
		.rst(rst),
		.ce(ce),
		.start(acc),
		.ncyc(ble_ncyc(acc_op)),
		.cnt(tm_cnt),
		.last(tm_last)
	);

	ble_target u_target (
		.op(op),
		.pc(q.pc),
		.y(q.y),
		.a(q.a),
		.b(q.b),
		.mem(q.mem),
		.imm(q.ir[7:0]),
		.ext(q.ext),
		.ext_on(q.f[FLAG_E]),
		.take(take),
		.target(tgt)
	);

	////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		d = q;
		d.pready = psel & ~q.pready;
		d.dm_rd = 1'b0;
		d.dm_wr = 1'b0;
		if (q.dm_rd)
			d.mem = dm_rdata;
		// answer built in setup so every bus output is a flop
		if (psel & ~penable)
		begin
			d.pslverr = pwrite & busy;
			d.prdata = 32'h0000_0000;
			if (paddr == REG_INSTR)
			begin
				d.prdata = {19'h00000, q.ir};
				if (pwrite & (acc_op == OP_NONE))
					d.pslverr = 1'b1;
			end
			else if (paddr == REG_STATUS)
				d.prdata = {24'h000000, q.f, 2'h0, q.f[FLAG_E], busy};
			else if (paddr == REG_PC)
				d.prdata = {16'h0000, q.pc};
			else if (paddr == REG_AB)
				d.prdata = {24'h000000, q.b, q.a};
			else if (paddr == REG_F)
				d.prdata = {28'h0000000, q.f};
			else if (paddr == REG_SP)
				d.prdata = {16'h0000, q.dsp, q.rsp};
			else if (paddr == REG_X)
				d.prdata = {16'h0000, q.x};
			else if (paddr == REG_Y)
				d.prdata = {16'h0000, q.y};
			else if (paddr == REG_EXT)
				d.prdata = {24'h000000, q.ext};
			else
				d.pslverr = 1'b1;
		end
		if (wr_ok)
		begin
			if (paddr == REG_PC)
				d.pc = pwdata[15:0];
			else if (paddr == REG_AB)
				{d.b, d.a} = pwdata[7:0];
			else if (paddr == REG_F)
				d.f = pwdata[3:0];
			else if (paddr == REG_SP)
				{d.dsp, d.rsp} = pwdata[15:0];
			else if (paddr == REG_X)
				d.x = pwdata[15:0];
			else if (paddr == REG_Y)
				d.y = pwdata[15:0];
			else if (paddr == REG_EXT)
			begin
				d.ext = pwdata[7:0];
				d.f[FLAG_E] = 1'b1;
			end
		end
		if (acc)
		begin
			d.ir = pwdata[12:0];
			d.st = ST_EXEC;
			if (acc_op == OP_LDIND)
			begin
				d.dm_rd = 1'b1;
				d.dm_addr = ind_addr(pwdata[12:0], q.x, q.y, q.ext, q.f[FLAG_E]);
			end
			else if (acc_op == OP_REL_MEM)
			begin
				d.dm_rd = 1'b1;
				d.dm_addr = {10'h000, pwdata[5:0]};
			end
			else if (acc_op == OP_TRAP)
			begin
				d.dm_wr = 1'b1;
				d.dm_addr = {8'h00, q.dsp - 8'h01};
				d.dm_wdata = q.f;
			end
		end
		if (busy & (op == OP_TRAP) & (tm_cnt < 3'h4))
		begin
			d.dm_wr = 1'b1;
			d.dm_addr = rsp_base + {14'h0000, tm_cnt[1:0]};
			d.dm_wdata = ret_addr[{tm_cnt[1:0], 2'h0} +: 4];
		end
		if (fire)
		begin
			d.st = ST_IDLE;
			d.pc = tgt;
			d.f[FLAG_E] = 1'b0;
			case (op)
				OP_INCSP:
				begin
					if (q.ir[2])
						d.dsp = sp_sum;
					else
						d.rsp = sp_sum;
					d.f[FLAG_Z] = (sp_sum == 8'h00);
				end
				OP_TRAP:
				begin
					d.rsp = q.rsp - 8'h01;
					d.dsp = q.dsp - 8'h01;
				end
				OP_LDRR:
				begin
					if (q.ir == CODE_LD_AB)
						d.a = q.b;
					else if (q.ir == CODE_LD_AF)
						d.a = q.f;
					else if (q.ir == CODE_LD_BA)
						d.b = q.a;
					else if (q.ir == CODE_LD_FA)
						d.f = q.a;
				end
				OP_LDIMM:
				begin
					if (q.ir[12:4] == PFX_LDI_A)
						d.a = q.ir[3:0];
					else if (q.ir[12:4] == PFX_LDI_B)
						d.b = q.ir[3:0];
					else
						d.f = q.ir[3:0];
				end
				OP_LDIND:
				begin
					if (q.ir[2])
						d.b = q.mem;
					else
						d.a = q.mem;
				end
				default: d.st = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			q <= '0;
		else if (ce)
			q <= d;
	end

	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign dm_addr = q.dm_addr;
	assign dm_rd = q.dm_rd;
	assign dm_wr = q.dm_wr;
	assign dm_wdata = q.dm_wdata;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	property p_incsp;
		fire && (op == OP_INCSP) |=> (q.f[FLAG_C] == $past(q.f[FLAG_C]))
			&& (q.f[FLAG_Z] == ((q.ir[2] ? q.dsp : q.rsp) == 8'h00));
	endproperty
	a_incsp: assert property (p_incsp) else $error("sp increment flags wrong");

	property p_trap_len;
		acc && ce && (acc_op == OP_TRAP) ##1 ce [*5] |=> tm_last;
	endproperty
	a_trap_len: assert property (p_trap_len) else $error("trap not three cycles");

	property p_trap_push;
		acc && ce && (acc_op == OP_TRAP) |=> q.dm_wr && (q.dm_wdata == $past(q.f))
			&& (q.dm_addr == {8'h00, $past(q.dsp) - 8'h01});
	endproperty
	a_trap_push: assert property (p_trap_push) else $error("trap flag push wrong");

	property p_trap_end;
		fire && (op == OP_TRAP) |=> (q.rsp == $past(q.rsp) - 8'h01)
			&& (q.dsp == $past(q.dsp) - 8'h01)
			&& (q.pc == VEC_BASE + {10'h000, $past(q.ir[5:0])});
	endproperty
	a_trap_end: assert property (p_trap_end) else $error("trap end state wrong");

	property p_jmp_y;
		fire && (op == OP_JMP_Y) |=> q.pc == $past(q.y);
	endproperty
	a_jmp_y: assert property (p_jmp_y) else $error("indirect jump target wrong");

	property p_rel_a;
		fire && (op == OP_REL_A) |=> q.pc == $past(q.pc) + 16'h0001 + {12'h000, $past(q.a)};
	endproperty
	a_rel_a: assert property (p_rel_a) else $error("digit jump target wrong");

	property p_rel_ba;
		acc && ce && (acc_op == OP_REL_BA) ##1 ce [*2] |=> !busy
			&& (q.pc == $past(q.pc) + 16'h0001 + {8'h00, $past(q.b), $past(q.a)});
	endproperty
	a_rel_ba: assert property (p_rel_ba) else $error("pair jump wrong");

	property p_rel_mem;
		acc && ce && (acc_op == OP_REL_MEM) ##1 ce [*3] |=> tm_last;
	endproperty
	a_rel_mem: assert property (p_rel_mem) else $error("memory jump not two cycles");

	property p_rel_s8;
		fire && (op == OP_REL_S8) && take && !q.f[FLAG_E] |=> q.pc == $past(q.pc) + 16'h0001
			+ {{8{$past(q.ir[7])}}, $past(q.ir[7:0])};
	endproperty
	a_rel_s8: assert property (p_rel_s8) else $error("short displacement wrong");

	property p_rel_s16;
		fire && (op == OP_REL_S8) && take && q.f[FLAG_E] |=> q.pc == $past(q.pc) + 16'h0001
			+ {$past(q.ext), $past(q.ir[7:0])};
	endproperty
	a_rel_s16: assert property (p_rel_s16) else $error("long displacement wrong");

	property p_skip_c;
		fire && (op == OP_REL_S8) && (q.ir[10:8] == COND_C) && !q.f[FLAG_C]
			|=> q.pc == $past(q.pc) + 16'h0001;
	endproperty
	a_skip_c: assert property (p_skip_c) else $error("carry branch taken wrongly");

	property p_skip_nc;
		fire && (op == OP_REL_S8) && (q.ir[10:8] == COND_NC) && q.f[FLAG_C]
			|=> q.pc == $past(q.pc) + 16'h0001;
	endproperty
	a_skip_nc: assert property (p_skip_nc) else $error("no-carry branch wrong");

	property p_skip_nz;
		fire && (op == OP_REL_S8) && (q.ir[10:8] == COND_NZ) && q.f[FLAG_Z]
			|=> q.pc == $past(q.pc) + 16'h0001;
	endproperty
	a_skip_nz: assert property (p_skip_nz) else $error("nonzero branch wrong");

	property p_skip_z;
		fire && (op == OP_REL_S8) && (q.ir[10:8] == COND_Z) && !q.f[FLAG_Z]
			|=> q.pc == $past(q.pc) + 16'h0001;
	endproperty
	a_skip_z: assert property (p_skip_z) else $error("zero branch wrong");

	property p_ld_fa;
		fire && (q.ir == CODE_LD_FA) |=> q.f == $past(q.a);
	endproperty
	a_ld_fa: assert property (p_ld_fa) else $error("flag copy wrong");

	property p_ldi_f;
		fire && (q.ir[12:4] == PFX_LDI_F) |=> q.f == $past(q.ir[3:0]);
	endproperty
	a_ldi_f: assert property (p_ldi_f) else $error("flag immediate wrong");

	property p_ldind;
		acc && ce && (acc_op == OP_LDIND) ##1 ce [*2] |=> !busy
			&& ((q.ir[2] ? q.b : q.a) == $past(q.mem));
	endproperty
	a_ldind: assert property (p_ldind) else $error("indirect load wrong");

	property p_ldind_page;
		q.dm_rd && busy && (op == OP_LDIND) && q.f[FLAG_E]
			|-> q.dm_addr == {(q.ir[1] ? PAGE_HI : PAGE_LO), q.ext};
	endproperty
	a_ldind_page: assert property (p_ldind_page) else $error("paged address wrong");

	property p_eclear;
		fire && (q.ir != CODE_LD_FA) && (q.ir[12:4] != PFX_LDI_F) |=> !q.f[FLAG_E];
	endproperty
	a_eclear: assert property (p_eclear) else $error("extension flag left set");

	c_trap: cover property (fire && (op == OP_TRAP));
	c_long: cover property (fire && (op == OP_REL_S8) && take && q.f[FLAG_E]);
	c_ldind: cover property (fire && (op == OP_LDIND) && q.f[FLAG_E]);
	c_mem: cover property (fire && (op == OP_REL_MEM));
endmodule // ble_exec

// ### verification/ble_dmem_model.sv
// data memory partner model: 64k nibbles, same-clock read, write at clock edge
module ble_dmem_model (
	input wire logic core_clk,
	input wire logic [15:0] dm_addr,
	input wire logic dm_rd,
	input wire logic dm_wr,
	input wire logic [3:0] dm_wdata,
	output logic [3:0] dm_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] mem [0:65535];
	logic [3:0] last;
	int wr_count;
	////////////////////////////////////////////////////////////////////////////////
	// fixed fill so every word differs from its neighbours within a 256-word page
	initial
	begin
		for (int i = 0; i < 65536; i++)
			mem[i] = 4'(i ^ (i >> 8));
		last = 4'h0;
		wr_count = 0;
	end
	// outside a read the bus toggles, so stale data is never taken for an answer
	always_comb
		dm_rdata = dm_rd ? mem[dm_addr] : ~last;
	always @(posedge core_clk)
	begin
		last <= dm_rdata;
		if (dm_wr)
		begin
			mem[dm_addr] <= dm_wdata;
			wr_count <= wr_count + 1;
		end
	end
endmodule // ble_dmem_model

// ### verification/ble_exec_tb.sv
// self-checking bench for the branch, trap and load executor
module ble_exec_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import ble_pkg::*;
	logic core_clk, rst, ce, psel, penable, pwrite, pready, pslverr, dm_rd, dm_wr, err;
	logic [APB_AW-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] dm_addr;
	logic [3:0] dm_wdata, dm_rdata;
	int err_total, num_checks, wr0;
	typedef struct {logic [15:0] pc; logic [7:0] ab; logic [3:0] f; logic [12:0] code;
		logic [15:0] epc; logic [7:0] eab; logic [3:0] ef;} ble_row_t;
	ble_row_t rows[$];
	////////////////////////////////////////////////////////////////////////////////
	ble_exec uut (.core_clk(core_clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .dm_addr(dm_addr), .dm_rd(dm_rd), .dm_wr(dm_wr),
		.dm_wdata(dm_wdata), .dm_rdata(dm_rdata));
	ble_dmem_model mem_m (.core_clk(core_clk), .dm_addr(dm_addr), .dm_rd(dm_rd),
		.dm_wr(dm_wr), .dm_wdata(dm_wdata), .dm_rdata(dm_rdata));
	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		if (err_total == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one idle clock before setup keeps strobes from being driven twice per step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1 && n < 20)
		begin
			n++;
			@(posedge core_clk);
		end
		if (pready !== 1'b1)
		begin
			err_total++;
			stop_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		check({31'h0, err}, 32'h0);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rd, exp);
	endtask
	task automatic wait_idle();
		for (int n = 0; n < 40; n++)
		begin
			apb(1'b0, REG_STATUS, 32'h0);
			if (rd[0] === 1'b0)
				return;
		end
		err_total++;
		stop_test();
	endtask
	task automatic exec(input logic [12:0] code);
		wr(REG_INSTR, {19'h0, code});
		wait_idle();
	endtask
	task automatic add(input logic [15:0] pc, input logic [7:0] ab, input logic [3:0] f,
		input logic [12:0] code, input logic [15:0] epc, input logic [7:0] eab,
		input logic [3:0] ef);
		rows.push_back('{pc, ab, f, code, epc, eab, ef});
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		err_total = 0;
		num_checks = 0;
		rst = 1'b1;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		add(16'h0010, 8'h0F, 4'h0, 13'h1FF1, 16'h0020, 8'h0F, 4'h0);
		add(16'h0100, 8'hFF, 4'h0, 13'h1FF0, 16'h0200, 8'hFF, 4'h0);
		add(16'h0050, 8'h00, 4'h0, 13'h1FF2, 16'h1234, 8'h00, 4'h0);
		add(16'h0050, 8'h00, 4'h0, 13'h1FF3, 16'h1234, 8'h00, 4'h0);
		add(16'h0300, 8'h00, 4'h0, 13'h1F6A, 16'h030B, 8'h00, 4'h0);
		add(16'h1000, 8'h00, 4'h0, 13'h0080, 16'h0F81, 8'h00, 4'h0);
		add(16'hFFF0, 8'h00, 4'h0, 13'h007F, 16'h0070, 8'h00, 4'h0);
		add(16'h0200, 8'h00, 4'h2, 13'h0410, 16'h0211, 8'h00, 4'h2);
		add(16'h0200, 8'h00, 4'h0, 13'h0410, 16'h0201, 8'h00, 4'h0);
		add(16'h0200, 8'h00, 4'h0, 13'h05F0, 16'h01F1, 8'h00, 4'h0);
		add(16'h0200, 8'h00, 4'h2, 13'h05F0, 16'h0201, 8'h00, 4'h2);
		add(16'h0200, 8'h00, 4'h1, 13'h0605, 16'h0206, 8'h00, 4'h1);
		add(16'h0200, 8'h00, 4'h0, 13'h0605, 16'h0201, 8'h00, 4'h0);
		add(16'h0200, 8'h00, 4'h0, 13'h0705, 16'h0206, 8'h00, 4'h0);
		add(16'h0200, 8'h00, 4'h1, 13'h0705, 16'h0201, 8'h00, 4'h1);
		add(16'h0040, 8'h5A, 4'h0, 13'h1EF2, 16'h0041, 8'h55, 4'h0);
		add(16'h0040, 8'h5A, 4'h0, 13'h1EF4, 16'h0041, 8'hAA, 4'h0);
		add(16'h0040, 8'h5A, 4'h0, 13'h1EF0, 16'h0041, 8'h5A, 4'h0);
		add(16'h0040, 8'h5A, 4'h0, 13'h1EF6, 16'h0041, 8'h5A, 4'h0);
		add(16'h0040, 8'h5A, 4'h6, 13'h1FF6, 16'h0041, 8'h56, 4'h6);
		add(16'h0040, 8'h5B, 4'h0, 13'h1FF5, 16'h0041, 8'h5B, 4'hB);
		add(16'h0040, 8'h5A, 4'h0, 13'h1EC9, 16'h0041, 8'h59, 4'h0);
		add(16'h0040, 8'h5A, 4'h0, 13'h1ED3, 16'h0041, 8'h3A, 4'h0);
		add(16'h0040, 8'h5A, 4'h0, 13'h10B7, 16'h0041, 8'h5A, 4'h7);
		add(16'h0040, 8'h00, 4'h0, 13'h1EE0, 16'h0041, 8'h0A, 4'h0);
		add(16'h0040, 8'h00, 4'h0, 13'h1EE2, 16'h0041, 8'h06, 4'h0);
		add(16'h0040, 8'h00, 4'h0, 13'h1EE4, 16'h0041, 8'hA0, 4'h0);
		add(16'h0040, 8'h00, 4'h0, 13'h1EE6, 16'h0041, 8'h60, 4'h0);
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		// pc, digit pair, flags and stack pointers read zero straight after reset
		rdchk(REG_PC, 32'h0);
		rdchk(REG_AB, 32'h0);
		rdchk(REG_F, 32'h0);
		rdchk(REG_SP, 32'h0);
		wr(REG_X, 32'h0349);
		wr(REG_Y, 32'h1234);
		foreach (rows[i])
		begin
			wr(REG_PC, {16'h0, rows[i].pc});
			wr(REG_AB, {24'h0, rows[i].ab});
			wr(REG_F, {28'h0, rows[i].f});
			exec(rows[i].code);
			rdchk(REG_PC, {16'h0, rows[i].epc});
			rdchk(REG_AB, {24'h0, rows[i].eab});
			rdchk(REG_F, {28'h0, rows[i].ef});
		end
		// stack pointer increments wrap and leave carry alone
		wr(REG_SP, 32'h00FF);
		wr(REG_F, 32'h2);
		exec(13'h1FE8);
		rdchk(REG_SP, 32'h0000);
		rdchk(REG_F, 32'h3);
		exec(13'h1FEC);
		rdchk(REG_SP, 32'h0100);
		rdchk(REG_F, 32'h2);
		// extension prefix widens one jump only
		wr(REG_PC, 32'h1000);
		wr(REG_F, 32'h0);
		wr(REG_EXT, 32'hFE);
		exec(13'h0010);
		rdchk(REG_PC, 32'h0E11);
		rdchk(REG_F, 32'h0);
		exec(13'h0010);
		rdchk(REG_PC, 32'h0E22);
		wr(REG_AB, 32'h0);
		wr(REG_EXT, 32'h34);
		rdchk(REG_STATUS, 32'h82);
		rdchk(REG_EXT, 32'h34);
		exec(13'h1EE0);
		rdchk(REG_AB, 32'h04);
		rdchk(REG_STATUS, 32'h0);
		rdchk(REG_INSTR, 32'h1EE0);
		rdchk(REG_Y, 32'h1234);
		wr(REG_EXT, 32'h34);
		exec(13'h1EE6);
		rdchk(REG_AB, 32'hB4);
		// trap, with a refused write while it runs
		wr(REG_PC, 32'h0200);
		wr(REG_F, 32'h6);
		wr(REG_SP, 32'h1008);
		wr0 = mem_m.wr_count;
		wr(REG_INSTR, 32'h1F95);
		apb(1'b1, REG_PC, 32'hFFFF);
		check({31'h0, err}, 32'h1);
		wait_idle();
		rdchk(REG_PC, 32'h0115);
		rdchk(REG_SP, 32'h0F07);
		rdchk(REG_F, 32'h6);
		check({28'h0, mem_m.mem[16'h000F]}, 32'h6);
		check({16'h0, mem_m.mem[16'h001F], mem_m.mem[16'h001E], mem_m.mem[16'h001D],
			mem_m.mem[16'h001C]}, 32'h0201);
		check(mem_m.wr_count - wr0, 32'd5);
		// handler clobbers flags, then the bench writes them back from the copy on the data stack
		wr(REG_F, 32'h0);
		wr(REG_F, {28'h0, mem_m.mem[16'h000F]});
		rdchk(REG_F, 32'h6);
		// unmapped address and a code outside the group are refused
		apb(1'b0, 8'h24, 32'h0);
		check({31'h0, err}, 32'h1);
		check(rd, 32'h0);
		apb(1'b1, REG_INSTR, 32'h1FFC);
		check({31'h0, err}, 32'h1);
		rdchk(REG_PC, 32'h0115);
		// a low clock enable only stretches the memory jump, never changes its result
		wr(REG_INSTR, 32'h1F6A);
		ce <= 1'b0;
		repeat (3) @(posedge core_clk);
		ce <= 1'b1;
		wait_idle();
		rdchk(REG_PC, 32'h0120);
		stop_test();
	end
endmodule // ble_exec_tb
